// [common/dual_irq_pkg.sv]
package dual_irq_pkg;

    // =====================================================================
    // Widths
    // =====================================================================
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EVT_W  = 2;

    // =====================================================================
    // Register byte addresses
    // =====================================================================
    localparam logic [ADDR_W-1:0] NORMAL_MASKED_STATUS_ADDR     = 32'hffff_0000;
    localparam logic [ADDR_W-1:0] NORMAL_RAW_SOURCE_STATUS_ADDR = 32'hffff_0004;
    localparam logic [ADDR_W-1:0] NORMAL_ENABLE_MASK_ADDR       = 32'hffff_0008;
    localparam logic [ADDR_W-1:0] NORMAL_MASK_CLEAR_ADDR        = 32'hffff_000c;
    localparam logic [ADDR_W-1:0] FAST_MASKED_STATUS_ADDR       = 32'hffff_0020;
    localparam logic [ADDR_W-1:0] FAST_RAW_SOURCE_STATUS_ADDR   = 32'hffff_0024;
    localparam logic [ADDR_W-1:0] FAST_ENABLE_MASK_ADDR         = 32'hffff_0028;
    localparam logic [ADDR_W-1:0] FAST_MASK_CLEAR_ADDR          = 32'hffff_002c;
    localparam logic [ADDR_W-1:0] PROGRAMMED_INTERRUPT_CFG_ADDR = 32'hffff_0030;
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR             = 32'hffff_0034;
    localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR               = 32'hffff_0038;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int unsigned FAST_OR_BIT  = 0;
    localparam int unsigned SW_IRQ_BIT   = 1;
    localparam int unsigned SWI_NORM_BIT = 1;
    localparam int unsigned SWI_FAST_BIT = 2;
    localparam int unsigned EVT_NORM_BIT = 0;
    localparam int unsigned EVT_FAST_BIT = 1;

    // Peripheral sources on bits 2..19, bit 15 reserved
    localparam logic [DATA_W-1:0] SRC_IMPL_MASK = 32'h000f_7ffc;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [DATA_W-1:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SWI_RST    = 32'h0000_0000;
    localparam logic [EVT_W-1:0]  EVT_RST    = 2'h0;

    // =====================================================================
    // Carriers
    // =====================================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic normal;
        logic fast;
    } irq_req_t;

endpackage : dual_irq_pkg

// [verilog/irq_level_mask.sv]
`timescale 1ns/1ns
module irq_level_mask #(
    parameter logic [31:0] IMPL_MASK = 32'h000f_7ffc,
    parameter logic [31:0] RST_VAL   = 32'h0000_0000
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        set_stb_i,
    input  wire logic        clr_stb_i,
    input  wire logic        cross_stb_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] enable_o
);

    // =====================================================================
    // Enable mask: write-one-set, write-one-clear, cleared by other level
    // =====================================================================
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;

    always_comb
    begin
        enable_nxt = enable_r;
        if (set_stb_i)
        begin
            enable_nxt = enable_r | (wdata_i & IMPL_MASK);
        end
        else if (clr_stb_i)
        begin
            enable_nxt = enable_r & ~wdata_i;
        end
        else if (cross_stb_i)
        begin
            enable_nxt = enable_r & ~(wdata_i & IMPL_MASK);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            enable_r <= RST_VAL;
        end
        else
        begin
            enable_r <= enable_nxt;
        end
    end

    assign enable_o = enable_r;

endmodule : irq_level_mask

// [verilog/event_status.sv]
`timescale 1ns/1ns
module event_status #(
    parameter int unsigned          W       = 2,
    parameter logic        [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] event_i,
    input  wire logic         status_wr_i,
    input  wire logic         mask_wr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] status_o,
    output logic      [W-1:0] mask_o,
    output logic              irq_o
);

    logic [W-1:0] status_r;
    logic [W-1:0] mask_r;

    // =====================================================================
    // Sticky status, write one to clear; a new event wins over the clear
    // =====================================================================
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            status_r <= RST_VAL;
        end
        else
        begin
            status_r <= (status_r & ~(status_wr_i ? wdata_i : '0)) | event_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            mask_r <= RST_VAL;
        end
        else if (mask_wr_i)
        begin
            mask_r <= wdata_i;
        end
    end

    assign status_o = status_r;
    assign mask_o   = mask_r;
    assign irq_o    = |(status_r & mask_r);

endmodule : event_status

// [verilog/dual_level_interrupt_controller.sv]
`timescale 1ns/1ns
// Behaviour
// [R1] Normal request is OR of normal masked status
// [R2] Normal masked bit needs source and enable
// [R3] No priority encoder, no vector
// [R4] Raw status follows peripheral request, read-only
// [R5] Write one enables; zero does nothing
// [R6] Mask-clear ones clear enables, others kept
// [R7] Fast level mirrors the normal level
// [R8] Fast request OR, also bit 0 both sets
// [R9] Fast enable write clears normal enable bit
// [R10] Normal enable write clears fast enable bit
// [R11] Source may be disabled in both masks
// [R12] Software interrupts bypass enable masks
// [R13] Config bit 2 drives fast bit 1
// [R14] Config bit 1 drives normal bit 1
// [R15] Sources hold request past minimum latency
// [R16] Bit map: 0 fast OR, 1 software, 2..19
// [R17] Mask-clear reads zero; status writes ignored
module dual_level_interrupt_controller #(
    parameter logic [31:0] SRC_MASK = dual_irq_pkg::SRC_IMPL_MASK
) (
    input  wire logic                                sys_clk_i,
    input  wire logic                                rst_n_i,
    input  wire dual_irq_pkg::bus_req_t              bus_req_i,
    output logic        [dual_irq_pkg::DATA_W-1:0]   bus_rdata_o,
    input  wire logic   [31:0]                       src_req_i,
    output dual_irq_pkg::irq_req_t                   core_req_o,
    output logic                                     evt_irq_o
);

    // =====================================================================
    // Write decode
    // =====================================================================
    logic        wr_norm_en;
    logic        wr_norm_clr;
    logic        wr_fast_en;
    logic        wr_fast_clr;
    logic        wr_swi;
    logic        wr_evt_sts;
    logic        wr_evt_msk;
    logic [31:0] wdata;

    assign wdata = bus_req_i.wdata;

    always_comb
    begin
        wr_norm_en  = 1'b0;
        wr_norm_clr = 1'b0;
        wr_fast_en  = 1'b0;
        wr_fast_clr = 1'b0;
        wr_swi      = 1'b0;
        wr_evt_sts  = 1'b0;
        wr_evt_msk  = 1'b0;
        if (!bus_req_i.wr)
        begin
            wr_swi = 1'b0;
        end
        else if (bus_req_i.addr == dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR)
        begin
            wr_norm_en = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR)
        begin
            wr_norm_clr = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::FAST_ENABLE_MASK_ADDR)
        begin
            wr_fast_en = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::FAST_MASK_CLEAR_ADDR)
        begin
            wr_fast_clr = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR)
        begin
            wr_swi = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::EVENT_STATUS_ADDR)
        begin
            wr_evt_sts = 1'b1;
        end
        else if (bus_req_i.addr == dual_irq_pkg::EVENT_MASK_ADDR)
        begin
            wr_evt_msk = 1'b1;
        end
        // Masked and raw status registers are read-only: writes fall through unused [R17]
    end

    // =====================================================================
    // Raw source capture
    // =====================================================================
    // One register stage; a source shorter than a cycle may be missed
    logic [31:0] src_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            src_r <= '0;
        end
        else
        begin
            src_r <= src_req_i & SRC_MASK; // [R4] [R15] [R16]
        end
    end

    // =====================================================================
    // Programmed interrupt configuration
    // =====================================================================
    logic [31:0] swi_cfg_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            swi_cfg_r <= dual_irq_pkg::SWI_RST;
        end
        else if (wr_swi)
        begin
            swi_cfg_r <= '0;
            swi_cfg_r[dual_irq_pkg::SWI_NORM_BIT] <= wdata[dual_irq_pkg::SWI_NORM_BIT]; // [R14]
            swi_cfg_r[dual_irq_pkg::SWI_FAST_BIT] <= wdata[dual_irq_pkg::SWI_FAST_BIT]; // [R13]
        end
    end

    // =====================================================================
    // Enable masks, mutually exclusive per source
    // =====================================================================
    logic [31:0] norm_en;
    logic [31:0] fast_en;

    irq_level_mask #(
        .IMPL_MASK (SRC_MASK),
        .RST_VAL   (dual_irq_pkg::ENABLE_RST)
    ) u_norm_mask (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .set_stb_i   (wr_norm_en),  // [R5]
        .clr_stb_i   (wr_norm_clr), // [R6]
        .cross_stb_i (wr_fast_en),  // [R9] [R11]
        .wdata_i     (wdata),
        .enable_o    (norm_en)
    );

    irq_level_mask #(
        .IMPL_MASK (SRC_MASK),
        .RST_VAL   (dual_irq_pkg::ENABLE_RST)
    ) u_fast_mask (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .set_stb_i   (wr_fast_en),  // [R7]
        .clr_stb_i   (wr_fast_clr), // [R7]
        .cross_stb_i (wr_norm_en),  // [R10]
        .wdata_i     (wdata),
        .enable_o    (fast_en)
    );

    // =====================================================================
    // Raw and masked status views
    // =====================================================================
    logic [31:0] fast_raw;
    logic [31:0] fast_masked;
    logic [31:0] norm_raw;
    logic [31:0] norm_masked;
    logic        fast_or;

    always_comb
    begin
        fast_raw    = src_r; // [R7]
        fast_masked = src_r & fast_en;
        fast_raw[dual_irq_pkg::SW_IRQ_BIT]    = swi_cfg_r[dual_irq_pkg::SWI_FAST_BIT]; // [R13]
        fast_masked[dual_irq_pkg::SW_IRQ_BIT] = swi_cfg_r[dual_irq_pkg::SWI_FAST_BIT]; // [R12]
        fast_or = |fast_masked[31:1]; // [R8]
        fast_raw[dual_irq_pkg::FAST_OR_BIT]    = fast_or; // [R8] [R16]
        fast_masked[dual_irq_pkg::FAST_OR_BIT] = fast_or;
    end

    always_comb
    begin
        norm_raw    = src_r;           // [R4]
        norm_masked = src_r & norm_en; // [R2]
        norm_raw[dual_irq_pkg::SW_IRQ_BIT]    = swi_cfg_r[dual_irq_pkg::SWI_NORM_BIT]; // [R14]
        norm_masked[dual_irq_pkg::SW_IRQ_BIT] = swi_cfg_r[dual_irq_pkg::SWI_NORM_BIT]; // [R12]
        norm_raw[dual_irq_pkg::FAST_OR_BIT]   = fast_or; // [R8]
    end

    // =====================================================================
    // Requests to the core: plain OR, no priority or vector [R3]
    // =====================================================================
    dual_irq_pkg::irq_req_t req_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            req_r <= '0;
        end
        else
        begin
            req_r.normal <= |norm_masked; // [R1]
            req_r.fast   <= fast_or;      // [R8]
        end
    end

    assign core_req_o = req_r;

    // =====================================================================
    // Event status: rising edges of each request
    // =====================================================================
    logic [dual_irq_pkg::EVT_W-1:0] evt_pulse;
    logic [dual_irq_pkg::EVT_W-1:0] evt_sts;
    logic [dual_irq_pkg::EVT_W-1:0] evt_msk;

    always_comb
    begin
        evt_pulse = '0;
        evt_pulse[dual_irq_pkg::EVT_NORM_BIT] = (|norm_masked) & ~req_r.normal;
        evt_pulse[dual_irq_pkg::EVT_FAST_BIT] = fast_or & ~req_r.fast;
    end

    event_status #(
        .W       (dual_irq_pkg::EVT_W),
        .RST_VAL (dual_irq_pkg::EVT_RST)
    ) u_evt (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .event_i     (evt_pulse),
        .status_wr_i (wr_evt_sts),
        .mask_wr_i   (wr_evt_msk),
        .wdata_i     (wdata[dual_irq_pkg::EVT_W-1:0]),
        .status_o    (evt_sts),
        .mask_o      (evt_msk),
        .irq_o       (evt_irq_o)
    );

    // =====================================================================
    // Read path, data one cycle after the strobe
    // =====================================================================
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;

    always_comb
    begin
        rdata_nxt = '0;
        if (!bus_req_i.rd)
        begin
            rdata_nxt = '0;
        end
        else if (bus_req_i.addr == dual_irq_pkg::NORMAL_MASKED_STATUS_ADDR)
        begin
            rdata_nxt = norm_masked;
        end
        else if (bus_req_i.addr == dual_irq_pkg::NORMAL_RAW_SOURCE_STATUS_ADDR)
        begin
            rdata_nxt = norm_raw;
        end
        else if (bus_req_i.addr == dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR)
        begin
            rdata_nxt = norm_en;
        end
        else if (bus_req_i.addr == dual_irq_pkg::FAST_MASKED_STATUS_ADDR)
        begin
            rdata_nxt = fast_masked;
        end
        else if (bus_req_i.addr == dual_irq_pkg::FAST_RAW_SOURCE_STATUS_ADDR)
        begin
            rdata_nxt = fast_raw;
        end
        else if (bus_req_i.addr == dual_irq_pkg::FAST_ENABLE_MASK_ADDR)
        begin
            rdata_nxt = fast_en;
        end
        else if (bus_req_i.addr == dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR)
        begin
            rdata_nxt = swi_cfg_r;
        end
        else if (bus_req_i.addr == dual_irq_pkg::EVENT_STATUS_ADDR)
        begin
            rdata_nxt = {30'h0000_0000, evt_sts};
        end
        else if (bus_req_i.addr == dual_irq_pkg::EVENT_MASK_ADDR)
        begin
            rdata_nxt = {30'h0000_0000, evt_msk};
        end
        // Mask-clear and unmapped addresses read zero [R17]
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign bus_rdata_o = rdata_r;

endmodule : dual_level_interrupt_controller

// [dv/dual_irq_chk.sv]
`timescale 1ns/1ns
module dual_irq_chk #(
    parameter logic [31:0] SRC_MASK = dual_irq_pkg::SRC_IMPL_MASK
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_n_i,
    input  wire dual_irq_pkg::bus_req_t          bus_req_i,
    input  wire logic [dual_irq_pkg::DATA_W-1:0] bus_rdata_o,
    input  wire logic [31:0]                     src_req_i,
    input  wire dual_irq_pkg::irq_req_t          core_req_o,
    input  wire logic                            evt_irq_o
);
    logic [31:0] nen_r;
    logic [31:0] fen_r;
    logic [31:0] swi_r;
    logic [31:0] wd;
    logic        nexp;
    logic        fexp;
    logic [31:0] ad;

    // =====================================================================
    // Shadow of the enable masks and programmed bits
    // =====================================================================
    assign wd   = bus_req_i.wdata & SRC_MASK;
    assign ad   = bus_req_i.addr;
    assign nexp = (|(src_req_i & nen_r)) | swi_r[1];
    assign fexp = (|(src_req_i & fen_r)) | swi_r[2];

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            nen_r <= 32'h0000_0000;
            fen_r <= 32'h0000_0000;
            swi_r <= 32'h0000_0000;
        end
        else if (bus_req_i.wr)
        begin
            if (ad == dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR)
            begin
                nen_r <= nen_r | wd;
                fen_r <= fen_r & ~wd;
            end
            if (ad == dual_irq_pkg::FAST_ENABLE_MASK_ADDR)
            begin
                fen_r <= fen_r | wd;
                nen_r <= nen_r & ~wd;
            end
            if (ad == dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR)
                nen_r <= nen_r & ~bus_req_i.wdata;
            if (ad == dual_irq_pkg::FAST_MASK_CLEAR_ADDR)
                fen_r <= fen_r & ~bus_req_i.wdata;
            if (ad == dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR)
                swi_r <= bus_req_i.wdata & 32'h0000_0006;
        end
    end

    // =====================================================================
    // Properties
    // =====================================================================
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_norm_req_on: assert property (nexp [*3] |-> core_req_o.normal)
        else $error("normal request missing");
    a_norm_req_off: assert property ((!nexp) [*3] |-> !core_req_o.normal)
        else $error("normal request without cause");
    a_fast_req_on: assert property (fexp [*3] |-> core_req_o.fast)
        else $error("fast request missing");
    a_fast_req_off: assert property ((!fexp) [*3] |-> !core_req_o.fast)
        else $error("fast request without cause");
    a_rdata_idle_zero: assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_nclr_reads_zero: assert property (bus_req_i.rd && ad == dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR
        |=> bus_rdata_o == 32'h0000_0000) else $error("normal mask clear read not zero");
    a_fclr_reads_zero: assert property (bus_req_i.rd && ad == dual_irq_pkg::FAST_MASK_CLEAR_ADDR
        |=> bus_rdata_o == 32'h0000_0000) else $error("fast mask clear read not zero");
    a_nen_read_val: assert property (bus_req_i.rd && ad == dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR
        |=> bus_rdata_o == $past(nen_r)) else $error("normal enable wrong");
    a_fen_read_val: assert property (bus_req_i.rd && ad == dual_irq_pkg::FAST_ENABLE_MASK_ADDR
        |=> bus_rdata_o == $past(fen_r)) else $error("fast enable wrong");
    a_cfg_read_val: assert property (bus_req_i.rd
        && ad == dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR
        |=> bus_rdata_o == $past(swi_r)) else $error("programmed config wrong");
endmodule : dual_irq_chk

bind dual_level_interrupt_controller dual_irq_chk #(.SRC_MASK(SRC_MASK)) chk_u (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .bus_req_i   (bus_req_i),
    .bus_rdata_o (bus_rdata_o),
    .src_req_i   (src_req_i),
    .core_req_o  (core_req_o),
    .evt_irq_o   (evt_irq_o)
);

// [dv/core_model.sv]
`timescale 1ns/1ns
module core_model (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire dual_irq_pkg::irq_req_t req_i,
    output logic [7:0]                  normal_entries_o,
    output logic [7:0]                  fast_entries_o
);
    dual_irq_pkg::irq_req_t prev_r;

    // Counts handler entries, one per rising request level
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            prev_r           <= '0;
            normal_entries_o <= 8'h00;
            fast_entries_o   <= 8'h00;
        end
        else
        begin
            prev_r           <= req_i;
            normal_entries_o <= normal_entries_o + 8'(req_i.normal && !prev_r.normal);
            fast_entries_o   <= fast_entries_o + 8'(req_i.fast && !prev_r.fast);
        end
    end
endmodule : core_model

// [dv/dual_level_interrupt_controller_tb.sv]
`timescale 1ns/1ns
module dual_level_interrupt_controller_tb;
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] nen;
        logic [31:0] fen;
        logic [31:0] cfg;
        logic [31:0] nm;
        logic [31:0] fm;
        logic [31:0] nraw;
        logic [1:0]  req;
    } row_t;
    logic                   sys_clk;
    logic                   rst_n;
    dual_irq_pkg::bus_req_t bus_req;
    logic [31:0]            bus_rdata;
    logic [31:0]            src_req;
    dual_irq_pkg::irq_req_t core_req;
    logic                   evt_irq;
    logic [7:0]             n_entries;
    logic [7:0]             e0;
    logic [7:0]             f_entries;
    logic [7:0]             f0;
    int                     n_errors = 0;
    int                     checks = 0;
    row_t rows [7] = '{
        '{32'h0000_0004, 32'h0000_0004, 32'h0, 32'h0, 32'h4, 32'h0, 32'h4, 2'h2},
        '{32'h0000_0008, 32'h0000_0000, 32'h8, 32'h0, 32'h0, 32'h9, 32'h9, 2'h1},
        '{32'h0000_0010, 32'h0000_0010, 32'h10, 32'h0, 32'h0, 32'h11, 32'h11, 2'h1},
        '{32'h000f_fffc, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h000f_7ffc, 2'h0},
        '{32'h0000_0000, 32'h0, 32'h0, 32'h2, 32'h2, 32'h0, 32'h2, 2'h2},
        '{32'h0000_0000, 32'h0, 32'h0, 32'h4, 32'h0, 32'h3, 32'h1, 2'h1},
        '{32'h0010_8000, 32'hffff_ffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 2'h0}};

    dual_level_interrupt_controller dut_u (
        .sys_clk_i   (sys_clk),
        .rst_n_i     (rst_n),
        .bus_req_i   (bus_req),
        .bus_rdata_o (bus_rdata),
        .src_req_i   (src_req),
        .core_req_o  (core_req),
        .evt_irq_o   (evt_irq)
    );
    core_model core_u (
        .sys_clk_i        (sys_clk),
        .rst_n_i          (rst_n),
        .req_i            (core_req),
        .normal_entries_o (n_entries),
        .fast_entries_o   (f_entries)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // =====================================================================
    // Bus and check tasks
    // =====================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Observed value is picked at the falling edge, where it is settled
    task automatic see(input int sel, input logic [31:0] exp);
        logic [31:0] got;
        @(negedge sys_clk);
        case (sel)
            0: got = {30'h0, core_req};
            1: got = {31'h0, evt_irq};
            2: got = {24'h0, n_entries};
            default: got = {24'h0, f_entries};
        endcase
        chk(got, exp);
        @(posedge sys_clk);
    endtask : see
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        @(negedge sys_clk);
        chk(bus_rdata, exp);
        @(posedge sys_clk);
    endtask : rd
    task automatic idle(input int n);
        bus_req <= '0;
        repeat (n) @(posedge sys_clk);
    endtask : idle
    task automatic finish_test;
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial
    begin
        rst_n = 1'b0;
        bus_req = '0;
        src_req = 32'h0000_0000;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR, 32'hffff_ffff);
            wr(dual_irq_pkg::FAST_MASK_CLEAR_ADDR, 32'hffff_ffff);
            wr(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, rows[i].nen);
            wr(dual_irq_pkg::FAST_ENABLE_MASK_ADDR, rows[i].fen);
            wr(dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR, rows[i].cfg);
            src_req <= rows[i].src;
            idle(3);
            see(0, {30'h0, rows[i].req});
            rd(dual_irq_pkg::NORMAL_MASKED_STATUS_ADDR, rows[i].nm);
            rd(dual_irq_pkg::FAST_MASKED_STATUS_ADDR, rows[i].fm);
            rd(dual_irq_pkg::NORMAL_RAW_SOURCE_STATUS_ADDR, rows[i].nraw);
        end
        // Event status: masked, then unmasked, then cleared
        wr(dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR, 32'hffff_ffff);
        wr(dual_irq_pkg::FAST_MASK_CLEAR_ADDR, 32'hffff_ffff);
        wr(dual_irq_pkg::EVENT_MASK_ADDR, 32'h0000_0000);
        idle(3);
        wr(dual_irq_pkg::EVENT_STATUS_ADDR, 32'h0000_0003);
        wr(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0100);
        idle(2);
        e0 = n_entries;
        src_req <= 32'h0000_0100;
        idle(4);
        see(1, 32'h0000_0000);
        see(2, {24'h0, e0 + 8'h01});
        rd(dual_irq_pkg::EVENT_STATUS_ADDR, 32'h0000_0001);
        wr(dual_irq_pkg::EVENT_MASK_ADDR, 32'h0000_0001);
        idle(1);
        see(1, 32'h0000_0001);
        wr(dual_irq_pkg::EVENT_STATUS_ADDR, 32'h0000_0001);
        idle(1);
        see(1, 32'h0000_0000);
        // Cross clearing and write-one semantics, back to back
        wr(dual_irq_pkg::FAST_ENABLE_MASK_ADDR, 32'h0000_0020);
        wr(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0020);
        rd(dual_irq_pkg::FAST_ENABLE_MASK_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0120);
        wr(dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR, 32'hffff_ffff);
        wr(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0030);
        wr(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0000);
        wr(dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR, 32'h0000_0010);
        rd(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0020);
        // Read-only, write-only and unmapped places
        wr(dual_irq_pkg::NORMAL_MASKED_STATUS_ADDR, 32'hffff_ffff);
        rd(dual_irq_pkg::NORMAL_MASKED_STATUS_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::NORMAL_MASK_CLEAR_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::FAST_MASK_CLEAR_ADDR, 32'h0000_0000);
        rd(32'hffff_0040, 32'h0000_0000);
        // Reset in mid-run with a request pending
        f0 = f_entries;
        wr(dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR, 32'hffff_ffff);
        rd(dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR, 32'h0000_0006);
        see(0, 32'h0000_0003);
        see(3, {24'h0, f0 + 8'h01});
        rst_n <= 1'b0;
        idle(5);
        see(0, 32'h0000_0000);
        rst_n <= 1'b1;
        rd(dual_irq_pkg::NORMAL_ENABLE_MASK_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::FAST_ENABLE_MASK_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::PROGRAMMED_INTERRUPT_CFG_ADDR, 32'h0000_0000);
        rd(dual_irq_pkg::NORMAL_MASKED_STATUS_ADDR, 32'h0000_0000);
        finish_test();
    end
endmodule : dual_level_interrupt_controller_tb
